// ==== verilog/dcs_pkg.sv ====
package dcs_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_STR0 = 8'h00;
	localparam logic [7:0] ADDR_STR1 = 8'h04;
	localparam logic [7:0] ADDR_LTRK = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	localparam int ADDR_W = 8;
	// Register field positions
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_SWWP_LSB = 4;
	localparam int STAT_BUSY_BIT = 8;
	localparam int STAT_DONE_BIT = 9;
	// Status byte layout
	localparam int ERR_BIT = 7;
	localparam int CLS_CMD_BIT = 6;
	localparam int CLS_REC_BIT = 5;
	localparam int CLS_HW_BIT = 4;
	localparam logic [7:0] STATUS_OK = 8'h01;
	localparam logic [7:0] STATUS_CLEAR = 8'h00;
	// Command string class codes
	localparam logic [3:0] CS_STATUS_NZ = 4'h1;
	localparam logic [3:0] CS_NO_DRIVE = 4'h2;
	localparam logic [3:0] CS_MULTI_DRIVE = 4'h3;
	localparam logic [3:0] CS_BAD_CMD = 4'h4;
	localparam logic [3:0] CS_BAD_TRACK = 4'h5;
	localparam logic [3:0] CS_BAD_SECTOR = 4'h6;
	localparam logic [3:0] CS_BAD_BUFFER = 4'h7;
	localparam logic [3:0] CS_BAD_LTRACK = 4'h8;
	// Recoverable class codes
	localparam logic [3:0] RC_NOT_READY = 4'h1;
	localparam logic [3:0] RC_HW_PROTECT = 4'h2;
	localparam logic [3:0] RC_SW_PROTECT = 4'h3;
	// Hardware class codes
	localparam logic [3:0] HW_DRIVE_FAIL = 4'h1;
	localparam logic [3:0] HW_TRACK_ERR = 4'h2;
	localparam logic [3:0] HW_SYNC_ERR = 4'h3;
	localparam logic [3:0] HW_ID_CRC = 4'h4;
	localparam logic [3:0] HW_ID_FORMAT = 4'h5;
	localparam logic [3:0] HW_DATA_CRC = 4'h6;
	localparam logic [3:0] HW_DELETED = 4'h7;
	// Ranges and limits
	localparam logic [7:0] TRACK_MAX = 8'h4c;
	localparam logic [7:0] SECTOR_MIN = 8'h01;
	localparam logic [7:0] SECTOR_MAX = 8'h1a;
	localparam logic [3:0] RETRY_LIMIT = 4'ha;
	// Command numbers
	localparam logic [3:0] CMD_READ_ALL = 4'h0;
	localparam logic [3:0] CMD_WRITE = 4'h1;
	localparam logic [3:0] CMD_READ = 4'h2;
	localparam logic [3:0] CMD_FORMAT = 4'h3;
	localparam logic [3:0] CMD_VERIFY = 4'h4;
	localparam logic [3:0] CMD_WRITE_DEL = 4'h5;
	localparam logic [3:0] CMD_HOLE = 4'h6;
	localparam logic [3:0] CMD_ALIAS_FIRST = 4'h7;
	localparam logic [3:0] CMD_ALIAS_LAST = 4'hb;
	localparam logic [3:0] CMD_ALIAS_OFS = 4'h6;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CHECK = 2'b01,
		ST_RUN = 2'b10
	} dcs_state_e;

	typedef struct packed {
		logic [7:0] ltrack_lo;
		logic [7:0] ltrack_hi;
		logic [7:0] buf_hi;
		logic [7:0] buf_lo;
		logic [7:0] sector;
		logic [7:0] track_lo;
		logic [7:0] track_hi;
		logic [7:0] init_status;
		logic [7:0] cmd;
	} dcs_string_s;

	typedef struct packed {
		logic home_fail;
		logic track_miss;
		logic no_sector;
		logic id_crc;
		logic id_format;
		logic data_crc;
		logic deleted_mark;
		logic op_ok;
	} dcs_event_s;
endpackage

// ==== verilog/dcs_reporter.sv ====
// Contract
// - Status bit 7 is one on failure, zero on success.
// - A failure sets class bit 6, 5 or 4.
// - Command class code 1: status byte nonzero at start.
// - Command class code 2: no drive selected.
// - Command class code 3: more than one drive selected.
// - Command class code 4: illegal command number.
// - Command class code 5: physical track out of range.
// - Command class code 6: sector out of range.
// - Command class code 7: unacceptable data buffer location.
// - Command class code 8: illegal logical track.
// - Recoverable code 1: selected drive not ready at start.
// - Recoverable code 2: write refused on hardware-protected media.
// - Recoverable code 3: write refused on software-protected drive.
// - Hardware code 1: home failure or ready lost during operation.
// - Track mismatch retried 10 times, then hardware code 2.
// - Hardware code 3: sector not found within two revolutions.
// - Hardware code 4: identifier field CRC failure.
// - Hardware code 5: identifier field format error.
// - Data CRC failure retried 10 times, then hardware code 6.
// - Hardware code 7: deleted-data mark on a read.
// - Tracks 0 to 76, sectors 1 to 26; others illegal.
// - Success writes status with only bit 0 set.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
module dcs_reporter #(
	parameter int DRIVES = 4,
	parameter logic [15:0] BUF_LAST = 16'h7fff
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// AXI4-Lite slave
	input wire logic [dcs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [dcs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Drive pins
	input wire logic [DRIVES-1:0] drive_ready_pin,
	input wire logic [DRIVES-1:0] write_prot_pin,
	// Disk engine
	input wire dcs_pkg::dcs_event_s disk_ev,
	output logic op_start,
	output logic [3:0] op_cmd,
	output logic [DRIVES-1:0] op_drive,
	output logic seek_retry,
	output logic read_retry,
	// Completion
	output logic [7:0] status_byte,
	output logic done,
	output logic busy
);
	dcs_pkg::dcs_state_e state;
	dcs_pkg::dcs_string_s cur;
	dcs_pkg::dcs_string_s regs_str;
	logic [31:0] str0, str1, ltrk;
	logic [DRIVES-1:0] sw_wp;
	logic [DRIVES-1:0] rdy_s1, rdy_s2, rdy_s3, rdy_f;
	logic [DRIVES-1:0] wp_s1, wp_s2, wp_s3, wp_f;
	logic [3:0] trk_cnt, crc_cnt;
	logic aw_held, w_held;
	logic [dcs_pkg::ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = nw[i*8 +: 8];
		return res;
	endfunction

	// Bus write path: address and data taken in either order
	wire wr_fire = aw_held && w_held && !s_axi_bvalid;
	wire wr_str0 = wr_fire && aw_addr == dcs_pkg::ADDR_STR0;
	wire wr_str1 = wr_fire && aw_addr == dcs_pkg::ADDR_STR1;
	wire wr_ltrk = wr_fire && aw_addr == dcs_pkg::ADDR_LTRK;
	wire wr_ctrl = wr_fire && aw_addr == dcs_pkg::ADDR_CTRL;
	wire wr_stat = wr_fire && aw_addr == dcs_pkg::ADDR_STAT;
	wire wr_hit = wr_str0 || wr_str1 || wr_ltrk || wr_ctrl || wr_stat;
	wire wr_lane0 = w_strb[0];
	wire wr_lane1 = w_strb[1];
	wire start_req = wr_ctrl && wr_lane0 && w_data[dcs_pkg::CTRL_START_BIT] && state == dcs_pkg::ST_IDLE;
	wire clr_status = wr_stat && wr_lane0;
	wire clr_done = wr_stat && wr_lane1 && w_data[dcs_pkg::STAT_DONE_BIT];

	// Bus read path
	wire ar_fire = s_axi_arvalid && s_axi_arready;
	wire rd_str0 = s_axi_araddr == dcs_pkg::ADDR_STR0;
	wire rd_str1 = s_axi_araddr == dcs_pkg::ADDR_STR1;
	wire rd_ltrk = s_axi_araddr == dcs_pkg::ADDR_LTRK;
	wire rd_ctrl = s_axi_araddr == dcs_pkg::ADDR_CTRL;
	wire rd_stat = s_axi_araddr == dcs_pkg::ADDR_STAT;
	wire rd_hit = rd_str0 || rd_str1 || rd_ltrk || rd_ctrl || rd_stat;
	wire [31:0] ctrl_word = 32'(sw_wp) << dcs_pkg::CTRL_SWWP_LSB;
	wire [31:0] stat_word = {22'h0, done, busy, status_byte};
	wire [31:0] rd_word = rd_str0 ? str0 : rd_str1 ? str1 : rd_ltrk ? ltrk :
		rd_ctrl ? ctrl_word : rd_stat ? stat_word : 32'h0;

	assign regs_str = {ltrk[15:0], str1[23:0], str0};

	// Command decode of the latched string
	wire [3:0] cmd_num = cur.cmd[7:4];
	wire [DRIVES-1:0] drv = cur.cmd[DRIVES-1:0];
	wire cmd_legal = cmd_num <= dcs_pkg::CMD_ALIAS_LAST && cmd_num != dcs_pkg::CMD_HOLE;
	wire is_logical = cmd_num >= dcs_pkg::CMD_ALIAS_FIRST;
	wire [3:0] base = is_logical ? cmd_num - dcs_pkg::CMD_ALIAS_OFS : cmd_num;
	wire needs_sector = base == dcs_pkg::CMD_WRITE || base == dcs_pkg::CMD_READ ||
		base == dcs_pkg::CMD_VERIFY || base == dcs_pkg::CMD_WRITE_DEL;
	wire needs_buf = base == dcs_pkg::CMD_READ_ALL || base == dcs_pkg::CMD_WRITE || base == dcs_pkg::CMD_READ;
	wire is_write = base == dcs_pkg::CMD_WRITE || base == dcs_pkg::CMD_FORMAT || base == dcs_pkg::CMD_WRITE_DEL;
	wire is_read = base == dcs_pkg::CMD_READ || base == dcs_pkg::CMD_VERIFY;
	wire no_drive = drv == '0;
	wire multi_drive = (drv & (drv - 1'b1)) != '0;
	wire sel_ready = |(drv & rdy_f);
	wire sel_hw_wp = |(drv & wp_f);
	wire sel_sw_wp = |(drv & sw_wp);
	wire track_bad = cur.track_hi != 8'h0 || cur.track_lo > dcs_pkg::TRACK_MAX;
	wire sector_bad = cur.sector < dcs_pkg::SECTOR_MIN || cur.sector > dcs_pkg::SECTOR_MAX;
	wire ltrack_bad = cur.ltrack_hi != 8'h0 || cur.ltrack_lo > dcs_pkg::TRACK_MAX;
	wire buf_bad = {cur.buf_hi, cur.buf_lo} > BUF_LAST;

	// Checks in priority order; class bit and code chosen together
	// string checks
	wire [3:0] cs_code = cur.init_status != dcs_pkg::STATUS_CLEAR ? dcs_pkg::CS_STATUS_NZ :
		no_drive ? dcs_pkg::CS_NO_DRIVE :
		multi_drive ? dcs_pkg::CS_MULTI_DRIVE :
		!cmd_legal ? dcs_pkg::CS_BAD_CMD :
		track_bad ? dcs_pkg::CS_BAD_TRACK :
		(needs_sector && sector_bad) ? dcs_pkg::CS_BAD_SECTOR :
		(needs_buf && buf_bad) ? dcs_pkg::CS_BAD_BUFFER :
		(is_logical && ltrack_bad) ? dcs_pkg::CS_BAD_LTRACK : 4'h0;
	wire [3:0] rc_code = !sel_ready ? dcs_pkg::RC_NOT_READY :
		(is_write && sel_hw_wp) ? dcs_pkg::RC_HW_PROTECT :
		(is_write && sel_sw_wp) ? dcs_pkg::RC_SW_PROTECT : 4'h0;
	wire [7:0] check_status = cs_code != 4'h0 ? {4'b1100, cs_code} :
		rc_code != 4'h0 ? {4'b1010, rc_code} : dcs_pkg::STATUS_CLEAR;
	wire check_fail = check_status != dcs_pkg::STATUS_CLEAR;

	// Events while running, highest priority first
	wire in_run = state == dcs_pkg::ST_RUN;
	wire trk_spent = trk_cnt == dcs_pkg::RETRY_LIMIT;
	wire crc_spent = crc_cnt == dcs_pkg::RETRY_LIMIT;
	wire [3:0] hw_code = (disk_ev.home_fail || !sel_ready) ? dcs_pkg::HW_DRIVE_FAIL :
		(disk_ev.track_miss && trk_spent) ? dcs_pkg::HW_TRACK_ERR :
		disk_ev.track_miss ? 4'h0 :
		disk_ev.no_sector ? dcs_pkg::HW_SYNC_ERR :
		disk_ev.id_crc ? dcs_pkg::HW_ID_CRC :
		disk_ev.id_format ? dcs_pkg::HW_ID_FORMAT :
		(disk_ev.data_crc && crc_spent) ? dcs_pkg::HW_DATA_CRC :
		disk_ev.data_crc ? 4'h0 :
		(disk_ev.deleted_mark && is_read) ? dcs_pkg::HW_DELETED : 4'h0;
	wire hw_fail = hw_code != 4'h0;
	wire want_seek = !hw_fail && disk_ev.track_miss && !trk_spent;
	wire want_read = !hw_fail && !disk_ev.track_miss && disk_ev.data_crc && !crc_spent;
	wire run_ok = !hw_fail && !want_seek && !want_read && disk_ev.op_ok;
	wire [7:0] run_status = hw_fail ? {4'b1001, hw_code} : dcs_pkg::STATUS_OK;
	wire run_end = in_run && (hw_fail || run_ok);
	wire check_end = state == dcs_pkg::ST_CHECK && check_fail;
	wire report = run_end || check_end;
	wire [7:0] next_status = run_end ? run_status : check_status;

	// Pin inputs: three stages, change taken when stages two and three agree
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			{rdy_s1, rdy_s2, rdy_s3, rdy_f} <= '0;
			{wp_s1, wp_s2, wp_s3, wp_f} <= '0;
		end
		else
		begin
			{rdy_s3, rdy_s2, rdy_s1} <= {rdy_s2, rdy_s1, drive_ready_pin};
			{wp_s3, wp_s2, wp_s1} <= {wp_s2, wp_s1, write_prot_pin};
			rdy_f <= (~(rdy_s2 ^ rdy_s3) & rdy_s3) | ((rdy_s2 ^ rdy_s3) & rdy_f);
			wp_f <= (~(wp_s2 ^ wp_s3) & wp_s3) | ((wp_s2 ^ wp_s3) & wp_f);
		end
	end

	// AXI write channel
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			{aw_held, w_held, s_axi_bvalid} <= '0;
			{s_axi_awready, s_axi_wready} <= 2'b11;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_bresp <= dcs_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? dcs_pkg::RESP_OKAY : dcs_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				{s_axi_bvalid, aw_held, w_held} <= '0;
				{s_axi_awready, s_axi_wready} <= 2'b11;
			end
		end
	end

	// AXI read channel
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= dcs_pkg::RESP_OKAY;
		end
		else if (ar_fire)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? dcs_pkg::RESP_OKAY : dcs_pkg::RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Command string and control registers
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			{str0, str1, ltrk} <= '0;
			sw_wp <= '0;
		end
		else
		begin
			if (wr_str0)
				str0 <= merge(str0, w_data, w_strb);
			if (wr_str1)
				str1 <= merge(str1, w_data, w_strb);
			if (wr_ltrk)
				ltrk <= merge(ltrk, w_data, w_strb);
			if (wr_ctrl && wr_lane0)
				sw_wp <= w_data[dcs_pkg::CTRL_SWWP_LSB +: DRIVES];
		end
	end

	// Operation sequencer
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state <= dcs_pkg::ST_IDLE;
			cur <= '0;
			{trk_cnt, crc_cnt} <= '0;
		end
		else
		begin
			case (state)
				dcs_pkg::ST_IDLE:
					if (start_req)
					begin
						cur <= regs_str;
						{trk_cnt, crc_cnt} <= '0;
						state <= dcs_pkg::ST_CHECK;
					end
				dcs_pkg::ST_CHECK:
					state <= check_fail ? dcs_pkg::ST_IDLE : dcs_pkg::ST_RUN;
				dcs_pkg::ST_RUN:
				begin
					if (want_seek)
						trk_cnt <= trk_cnt + 1'b1;
					if (want_read)
						crc_cnt <= crc_cnt + 1'b1;
					if (run_end)
						state <= dcs_pkg::ST_IDLE;
				end
				default:
					state <= dcs_pkg::ST_IDLE;
			endcase
		end
	end

	// Outputs; a report in the same cycle as a software clear wins
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			{op_start, seek_retry, read_retry, done, busy} <= '0;
			op_cmd <= '0;
			op_drive <= '0;
			status_byte <= dcs_pkg::STATUS_CLEAR;
		end
		else
		begin
			op_start <= state == dcs_pkg::ST_CHECK && !check_fail;
			op_cmd <= cur.cmd[7:4];
			op_drive <= drv;
			seek_retry <= in_run && want_seek;
			read_retry <= in_run && want_read;
			busy <= (state == dcs_pkg::ST_IDLE) ? start_req : !report;
			if (report)
				status_byte <= next_status;
			else if (clr_status)
				status_byte <= w_data[7:0];
			if (report)
				done <= 1'b1;
			else if (clr_done || start_req)
				done <= 1'b0;
		end
	end

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_rep(logic [7:0] v);
		done && status_byte == v;
	endsequence

	property p_err_flag;
		report |=> done && (status_byte[dcs_pkg::ERR_BIT] == (status_byte != dcs_pkg::STATUS_OK));
	endproperty
	a_err_flag: assert property (p_err_flag) else $error("error flag does not match outcome");

	property p_one_class;
		report |=> status_byte[dcs_pkg::ERR_BIT] ? $onehot(status_byte[6:4]) : status_byte[6:4] == 3'h0;
	endproperty
	a_one_class: assert property (p_one_class) else $error("class bits not exactly one");

	property p_nz_status;
		state == dcs_pkg::ST_CHECK && cur.init_status != 8'h0 |=> s_rep(8'hc1) ##1 state == dcs_pkg::ST_IDLE;
	endproperty
	a_nz_status: assert property (p_nz_status) else $error("nonzero start status not reported");

	property p_no_drive;
		state == dcs_pkg::ST_CHECK && cur.init_status == 8'h0 && drv == '0 |=> s_rep(8'hc2);
	endproperty
	a_no_drive: assert property (p_no_drive) else $error("missing drive not reported");

	property p_bad_track;
		state == dcs_pkg::ST_CHECK && cs_code == 4'h5 |=> s_rep(8'hc5) ##0 !op_start;
	endproperty
	a_bad_track: assert property (p_bad_track) else $error("track range error not reported");

	property p_sw_wp;
		state == dcs_pkg::ST_CHECK && cs_code == 4'h0 && sel_ready && is_write && !sel_hw_wp && sel_sw_wp
			|=> s_rep(8'ha3) ##0 !op_start;
	endproperty
	a_sw_wp: assert property (p_sw_wp) else $error("software protect write not refused");

	property p_start_run;
		state == dcs_pkg::ST_CHECK && !check_fail |=> op_start && busy && state == dcs_pkg::ST_RUN;
	endproperty
	a_start_run: assert property (p_start_run) else $error("clean string did not start");

	property p_ready_drop;
		in_run && !sel_ready |=> s_rep(8'h91) ##0 !busy;
	endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("ready loss not reported");

	property p_trk_retry;
		in_run && !disk_ev.home_fail && sel_ready && disk_ev.track_miss && trk_cnt < 4'ha
			|=> seek_retry && trk_cnt == $past(trk_cnt) + 4'h1 && state == dcs_pkg::ST_RUN;
	endproperty
	a_trk_retry: assert property (p_trk_retry) else $error("track retry not issued");

	property p_trk_fail;
		in_run && !disk_ev.home_fail && sel_ready && disk_ev.track_miss && trk_cnt == 4'ha
			|=> s_rep(8'h92) ##0 !seek_retry;
	endproperty
	a_trk_fail: assert property (p_trk_fail) else $error("track error after retries missing");

	property p_crc_fail;
		in_run && hw_code == 4'h6 |=> s_rep(8'h96) ##1 !read_retry;
	endproperty
	a_crc_fail: assert property (p_crc_fail) else $error("data crc error not reported");

	property p_ok;
		in_run && run_ok |=> s_rep(8'h01) ##0 !busy;
	endproperty
	a_ok: assert property (p_ok) else $error("success byte wrong");
endmodule
`default_nettype wire

// ==== sim/dcs_disk_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module dcs_disk_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Plan set by the bench
	input wire logic [7:0] ev_pick,
	input wire logic [7:0] n_fail,
	input wire logic [7:0] dly,
	// Reporter side
	input wire logic op_start,
	input wire logic seek_retry,
	input wire logic read_retry,
	output var dcs_pkg::dcs_event_s disk_ev
);
	logic [7:0] tmr;
	logic [7:0] rem;
	// Offers the planned fault while faults remain, then answers clean
	always_ff @(posedge ref_clk)
	begin
		disk_ev <= 8'h00;
		if (!rst_n)
		begin
			tmr <= 8'h00;
			rem <= 8'h00;
		end
		else if (op_start)
		begin
			tmr <= dly;
			rem <= n_fail;
		end
		else if (seek_retry || read_retry)
		begin
			tmr <= dly;
			rem <= rem - 8'h01;
		end
		else if (tmr == 8'h01)
		begin
			tmr <= 8'h00;
			disk_ev <= (rem != 8'h00) ? ev_pick : 8'h01;
		end
		else if (tmr != 8'h00)
			tmr <= tmr - 8'h01;
	end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [3:0] drive_ready_pin = 4'hf;
	logic [3:0] write_prot_pin = 4'h0;
	logic [7:0] ev_pick = 8'h01;
	logic [7:0] n_fail = 8'h00;
	logic [7:0] dly = 8'h04;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic op_start, seek_retry, read_retry, done, busy;
	logic [3:0] op_cmd, op_drive;
	logic [7:0] status_byte;
	dcs_pkg::dcs_event_s disk_ev;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n_start = 0;
	int n_seek = 0;
	int n_read = 0;

	dcs_reporter u_dcs_reporter (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .drive_ready_pin, .write_prot_pin, .disk_ev, .op_start, .op_cmd,
		.op_drive, .seek_retry, .read_retry, .status_byte, .done, .busy);
	dcs_disk_model u_dcs_disk_model (.ref_clk, .rst_n, .ev_pick, .n_fail, .dly, .op_start,
		.seek_retry, .read_retry, .disk_ev);

	always #20 ref_clk = ~ref_clk;

	always @(posedge ref_clk)
	begin
		cyc++;
		n_start += (op_start === 1'b1);
		n_seek += (seek_retry === 1'b1);
		n_read += (read_retry === 1'b1);
		if (cyc == 20000)
		begin
			n_mismatch++;
			$display("Timeout after %0d cycles", cyc);
			test_done();
		end
	end

	task automatic test_done;
		$display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit ga;
		bit gw;
		ga = 0;
		gw = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ga && gw))
		begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready === 1'b1)
			begin
				ga = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1)
			begin
				gw = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Loads a string, starts it, waits for the report and judges it
	task automatic run_op(input logic [31:0] s0, s1, lt, ctl, input logic [7:0] ev, nf, dl,
		input int drop, input logic [7:0] exp, input int started);
		logic [1:0] r;
		ev_pick <= ev;
		n_fail <= nf;
		dly <= dl;
		wr(dcs_pkg::ADDR_STR0, s0, r);
		wr(dcs_pkg::ADDR_STR1, s1, r);
		wr(dcs_pkg::ADDR_LTRK, lt, r);
		n_start = 0;
		n_seek = 0;
		n_read = 0;
		wr(dcs_pkg::ADDR_CTRL, ctl | 32'h1, r);
		for (int i = 0; i < 2000 && done !== 1'b1; i++)
		begin
			@(posedge ref_clk);
			if (i == drop)
				drive_ready_pin <= 4'h0;
		end
		chk("status_byte", {24'h0, status_byte}, {24'h0, exp});
		chk("busy", {31'h0, busy}, 32'h0);
		chk("op_start count", n_start, started);
		chk("op_cmd", {28'h0, op_cmd}, {28'h0, s0[7:4]});
		chk("op_drive", {28'h0, op_drive}, {28'h0, s0[3:0]});
	endtask

	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rd(dcs_pkg::ADDR_STAT, d, r);
		chk("stat after reset", d, 32'h0);
		chk("stat resp", {30'h0, r}, {30'h0, dcs_pkg::RESP_OKAY});
		rd(8'h14, d, r);
		chk("unmapped rresp", {30'h0, r}, {30'h0, dcs_pkg::RESP_SLVERR});
		chk("unmapped rdata", d, 32'h0);
		wr(8'h14, 32'h1, r);
		chk("unmapped bresp", {30'h0, r}, {30'h0, dcs_pkg::RESP_SLVERR});
		wr(dcs_pkg::ADDR_CTRL, 32'hf0, r);
		chk("ctrl bresp", {30'h0, r}, {30'h0, dcs_pkg::RESP_OKAY});
		rd(dcs_pkg::ADDR_CTRL, d, r);
		chk("ctrl readback", d, 32'hf0);
		wr(dcs_pkg::ADDR_CTRL, 32'h0, r);
		$display("Test regs done");
	endtask

	// Each entry: STR0, STR1, LTRK, expected status; host does not clear status between entries
	task automatic t_cmd;
		logic [103:0] t [11];
		t[0] = {32'h0000_0521, 32'h01, 32'h0, 8'hc1};
		t[1] = {32'h0000_0020, 32'h01, 32'h0, 8'hc2};
		t[2] = {32'h0000_0023, 32'h01, 32'h0, 8'hc3};
		t[3] = {32'h0000_0061, 32'h01, 32'h0, 8'hc4};
		t[4] = {32'h0000_00c1, 32'h01, 32'h0, 8'hc4};
		t[5] = {32'h4d00_0021, 32'h01, 32'h0, 8'hc5};
		t[6] = {32'h0001_0021, 32'h01, 32'h0, 8'hc5};
		t[7] = {32'h0000_0021, 32'h00, 32'h0, 8'hc6};
		t[8] = {32'h0000_0021, 32'h1b, 32'h0, 8'hc6};
		t[9] = {32'h0000_0021, 32'h0080_0001, 32'h0, 8'hc7};
		t[10] = {32'h0000_0081, 32'h01, 32'h4d00, 8'hc8};
		foreach (t[i])
			run_op(t[i][103:72], t[i][71:40], t[i][39:8], 32'h0, 8'h01, 8'h01, 8'h04, -1, t[i][7:0], 0);
		$display("Test command string errors done");
	endtask

	task automatic t_rec;
		drive_ready_pin <= 4'he;
		idle(6);
		run_op(32'h21, 32'h01, 32'h0, 32'h0, 8'h01, 8'h01, 8'h04, -1, 8'ha1, 0);
		drive_ready_pin <= 4'hf;
		write_prot_pin <= 4'h1;
		idle(6);
		run_op(32'h11, 32'h01, 32'h0, 32'h0, 8'h01, 8'h01, 8'h04, -1, 8'ha2, 0);
		write_prot_pin <= 4'h0;
		idle(6);
		run_op(32'h11, 32'h01, 32'h0, 32'h10, 8'h01, 8'h01, 8'h04, -1, 8'ha3, 0);
		$display("Test recoverable errors done");
	endtask

	task automatic t_hw;
		logic [15:0] t [6];
		logic [1:0] r;
		t = '{16'h8091, 16'h2093, 16'h1094, 16'h0895, 16'h0297, 16'h0101};
		foreach (t[i])
			run_op(32'h4c00_0021, 32'h1a, 32'h0, 32'h0, t[i][15:8], 8'h01, 8'(1 + 8 * (i % 2)), -1, t[i][7:0], 1);
		run_op(32'h0500_0031, 32'h0, 32'h0, 32'h0, 8'h01, 8'h01, 8'h02, -1, 8'h01, 1);
		wr(dcs_pkg::ADDR_STAT, 32'h200, r);
		chk("done cleared", {31'h0, done}, 32'h0);
		$display("Test hardware errors done");
	endtask

	task automatic t_retry;
		run_op(32'h21, 32'h01, 32'h0, 32'h0, 8'h40, 8'h0b, 8'h02, -1, 8'h92, 1);
		chk("seek retries", n_seek, 32'h0a);
		run_op(32'h21, 32'h01, 32'h0, 32'h0, 8'h40, 8'h0a, 8'h02, -1, 8'h01, 1);
		chk("seek retries", n_seek, 32'h0a);
		run_op(32'h21, 32'h01, 32'h0, 32'h0, 8'h04, 8'h0b, 8'h02, -1, 8'h96, 1);
		chk("read retries", n_read, 32'h0a);
		$display("Test retries done");
	endtask

	task automatic t_loss;
		run_op(32'h21, 32'h01, 32'h0, 32'h0, 8'h01, 8'h01, 8'h3c, 5, 8'h91, 1);
		drive_ready_pin <= 4'hf;
		idle(6);
		$display("Test ready loss done");
	endtask

	initial
	begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		idle(6);
		t_regs();
		t_cmd();
		t_rec();
		t_hw();
		t_retry();
		t_loss();
		test_done();
	end
endmodule
`default_nettype wire
